// >>> shared/seq_pkg.sv
`default_nettype none
package seq_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_ALARM_CLR = 12'h004;
    localparam logic [3:0] TBL_PAGE = 4'h1;
    // Status register bit positions
    localparam int ST_READY = 0;
    localparam int ST_MOVE = 1;
    localparam int ST_END = 2;
    localparam int ST_TLC = 3;
    localparam int ST_ALARM = 4;
    localparam int ST_SEG_LSB = 8;
    // Table entry field positions
    localparam int FN_LSB = 0;
    localparam int SPD_LSB = 8;
    localparam int DW_LSB = 16;
    // Operation functions
    localparam logic [1:0] FN_SINGLE = 2'h0;
    localparam logic [1:0] FN_LINKED = 2'h1;
    localparam logic [1:0] FN_CHAIN_WITH_DWELL = 2'h2;
    localparam logic [1:0] FN_PUSH = 2'h3;
    // Motor current selection
    localparam logic [1:0] CUR_RUN = 2'h0;
    localparam logic [1:0] CUR_PUSH = 2'h1;
    localparam logic [1:0] CUR_STOP = 2'h2;
    // Limits
    localparam logic [7:0] PUSH_MAX_RPM = 8'h1e;
    localparam logic [2:0] CHAIN_ALARM_CNT = 3'h5;
    localparam logic [5:0] LAST_NO = 6'h3f;
    // Timing: dwell unit is one millisecond
    localparam int CLK_NS = 10;
    localparam int DWELL_UNIT_NS = 1000000;
    localparam int MS_CYCLES_DEF = DWELL_UNIT_NS / CLK_NS;
    // Reset values
    localparam logic RST_READY = 1'b1;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> rtl/push_link_seq.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Select before start; same-update start accepted
// - Ready drops on start; host then releases
// - Linked entries run continuously through dwell entry
// - Chain end: moving off, dwell held
// - Dwell over: next entry starts, moving on
// - Final single entry done: ready on
// - Push entry: constant speed, no ramp
// - Load pressed: push current, limit, ready
// - Torque limit flag before ready
// - Push target reached: end, ready, push current
// - Unpressed push completion keeps limit flag off
// - Stop during push: end, ready, stop current
// - Push speed above 30 raises alarm
// - Linked then push: ready at push end
// - Five linked entries raise alarm at start
// - Highest entry never wraps to zero
// - Chain uses start entry acceleration
module push_link_seq #(
    parameter int MS_CYCLES = seq_pkg::MS_CYCLES_DEF
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Host pins
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [5:0] i_data_select,
    // Motor engine handshake, same clock
    input wire logic i_seg_done,
    input wire logic i_load_pressed,
    output logic o_mot_run,
    output logic [5:0] o_mot_seg_no,
    output logic [5:0] o_mot_accel_no,
    output logic [7:0] o_mot_speed,
    output logic o_mot_ramp_en,
    output logic [1:0] o_mot_current,
    // Status pins
    output logic o_ready,
    output logic o_move,
    output logic o_end,
    output logic o_torque_limit_reached_out,
    output logic o_alarm
);
    typedef enum logic [2:0] {
        st_idle,
        st_scan,
        st_run,
        st_push_ack,
        st_dwell
    } state_e;

    // Pin synchronisers: select and start share stages, so a
    // same-update change reaches the logic in the same cycle
    logic [7:0] pin_s1_r; // First stage, read only by stage two
    logic [7:0] pin_s2_r; // Stable copy
    wire start_s = pin_s2_r[7];
    wire stop_s = pin_s2_r[6];
    wire [5:0] sel_s = pin_s2_r[5:0];

    // Operation data table, written by software
    logic [31:0] tbl_r [0:63];

    // Sequencer state
    state_e state_r, state_nxt;
    logic [5:0] idx_r, idx_nxt; // Current entry
    logic [5:0] first_r, first_nxt; // Entry the chain started at
    logic [2:0] cnt_r, cnt_nxt; // Linked entries seen in scan
    logic [15:0] dw_r, dw_nxt; // Dwell ms left
    logic [31:0] ms_r, ms_nxt; // Cycles within a ms
    logic ready_r, ready_nxt;
    logic move_r, move_nxt;
    logic end_r, end_nxt;
    logic tlc_r, tlc_nxt;
    logic alarm_r, alarm_nxt;
    logic run_r, run_nxt;
    logic [1:0] cur_r, cur_nxt;
    logic [7:0] spd_r;
    logic ramp_r;

    // AHB data phase state
    logic dp_wr_r; // Write pending
    logic [11:0] dp_addr_r;
    logic [31:0] rdata_r;

    // Entry decode for the current entry
    wire [31:0] ent = tbl_r[idx_r];
    wire [1:0] ent_fn = ent[seq_pkg::FN_LSB +: 2];
    wire [7:0] ent_spd = ent[seq_pkg::SPD_LSB +: 8];
    wire [15:0] ent_dw = ent[seq_pkg::DW_LSB +: 16];
    wire is_last = (idx_r == seq_pkg::LAST_NO);
    // Highest entry is never linked onward
    wire ent_linked = (ent_fn == seq_pkg::FN_LINKED) && !is_last;
    wire ent_dwell = (ent_fn == seq_pkg::FN_CHAIN_WITH_DWELL) && !is_last;
    wire ent_push = (ent_fn == seq_pkg::FN_PUSH);
    wire push_too_fast = ent_push && (ent_spd > seq_pkg::PUSH_MAX_RPM);
    wire [5:0] idx_inc = idx_r + 6'h01;
    wire ms_wrap = (ms_r == 32'(MS_CYCLES - 1));

    // Entry decode for the next entry, feeds motor speed flops
    wire [31:0] ent_n = tbl_r[idx_nxt];

    // AHB decode
    wire ap_take = i_hsel && i_hready && i_htrans[1];
    wire [11:0] ap_addr = i_haddr[11:0];
    wire ap_tbl = (ap_addr[11:8] == seq_pkg::TBL_PAGE);
    wire ap_stat = (ap_addr == seq_pkg::OFS_STATUS);
    wire dp_tbl = dp_wr_r && (dp_addr_r[11:8] == seq_pkg::TBL_PAGE);
    wire alarm_clr = dp_wr_r && (dp_addr_r == seq_pkg::OFS_ALARM_CLR) && i_hwdata[0];
    wire [31:0] stat_word = {18'h0, idx_r, 3'h0, alarm_r, tlc_r, end_r, move_r, ready_r};
    wire [31:0] rd_mux = ap_stat ? stat_word : (ap_tbl ? tbl_r[ap_addr[7:2]] : 32'h0);

    // Two-stage synchroniser on host pins
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
        end else begin
            pin_s1_r <= {i_start, i_stop, i_data_select};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Table write in the data phase; no reset, software loads it
    always_ff @(posedge i_clk_sys) begin
        if (dp_tbl) begin
            tbl_r[dp_addr_r[7:2]] <= i_hwdata;
        end
    end

    // AHB slave: zero wait states, read data registered
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= 12'h000;
            rdata_r <= seq_pkg::RST_RDATA;
        end else begin
            dp_wr_r <= ap_take && i_hwrite;
            dp_addr_r <= ap_take ? ap_addr : dp_addr_r;
            // Unmapped reads return zero
            rdata_r <= (ap_take && !i_hwrite) ? rd_mux : rdata_r;
        end
    end

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        first_nxt = first_r;
        cnt_nxt = cnt_r;
        dw_nxt = dw_r;
        ms_nxt = ms_r;
        ready_nxt = ready_r;
        move_nxt = move_r;
        end_nxt = end_r;
        tlc_nxt = tlc_r;
        run_nxt = run_r;
        cur_nxt = cur_r;
        // Alarm clear by software; a new alarm below overrides it
        alarm_nxt = alarm_r && !alarm_clr;
        case (state_r)
            st_idle: begin
                // Ready stays low while an alarm is pending
                ready_nxt = !alarm_r;
                // Start only taken while ready is shown
                if (ready_r && start_s && !alarm_r) begin
                    ready_nxt = 1'b0;
                    end_nxt = 1'b0;
                    tlc_nxt = 1'b0;
                    idx_nxt = sel_s;
                    first_nxt = sel_s;
                    cnt_nxt = 3'h0;
                    cur_nxt = seq_pkg::CUR_RUN;
                    state_nxt = st_scan;
                end
            end
            st_scan: begin
                // Walk the whole sequence once before moving
                if (push_too_fast) begin
                    alarm_nxt = 1'b1;
                    state_nxt = st_idle;
                end else if (ent_linked || ent_dwell) begin
                    if (cnt_r == seq_pkg::CHAIN_ALARM_CNT - 3'h1) begin
                        alarm_nxt = 1'b1;
                        state_nxt = st_idle;
                    end else begin
                        cnt_nxt = cnt_r + 3'h1;
                        idx_nxt = idx_inc;
                    end
                end else begin
                    // Sequence is legal: launch its first entry
                    idx_nxt = first_r;
                    run_nxt = 1'b1;
                    move_nxt = 1'b1;
                    state_nxt = st_run;
                end
            end
            st_run: begin
                if (stop_s) begin
                    // Stop holds with the stop current
                    run_nxt = 1'b0;
                    move_nxt = 1'b0;
                    end_nxt = 1'b1;
                    ready_nxt = 1'b1;
                    cur_nxt = seq_pkg::CUR_STOP;
                    state_nxt = st_idle;
                end else if (ent_push && i_load_pressed) begin
                    // Torque flag leads, ready follows next cycle
                    tlc_nxt = 1'b1;
                    cur_nxt = seq_pkg::CUR_PUSH;
                    move_nxt = 1'b0;
                    state_nxt = st_push_ack;
                end else if (i_seg_done) begin
                    if (ent_linked) begin
                        // No stop between linked entries
                        idx_nxt = idx_inc;
                    end else if (ent_dwell) begin
                        run_nxt = 1'b0;
                        move_nxt = 1'b0;
                        dw_nxt = ent_dw;
                        ms_nxt = 32'h0;
                        state_nxt = st_dwell;
                    end else begin
                        // Single or unpressed push: sequence over
                        run_nxt = 1'b0;
                        move_nxt = 1'b0;
                        end_nxt = 1'b1;
                        ready_nxt = 1'b1;
                        tlc_nxt = 1'b0;
                        if (ent_push) begin
                            cur_nxt = seq_pkg::CUR_PUSH;
                        end
                        state_nxt = st_idle;
                    end
                end
            end
            st_push_ack: begin
                // Run drops, push current held; ready now follows the flag
                run_nxt = 1'b0;
                ready_nxt = 1'b1;
                state_nxt = st_idle;
            end
            st_dwell: begin
                if (stop_s) begin
                    end_nxt = 1'b1;
                    ready_nxt = 1'b1;
                    cur_nxt = seq_pkg::CUR_STOP;
                    state_nxt = st_idle;
                end else if (dw_r == 16'h0) begin
                    // Next entry starts a fresh chain
                    idx_nxt = idx_inc;
                    first_nxt = idx_inc;
                    run_nxt = 1'b1;
                    move_nxt = 1'b1;
                    state_nxt = st_run;
                end else if (ms_wrap) begin
                    ms_nxt = 32'h0;
                    dw_nxt = dw_r - 16'h1;
                end else begin
                    ms_nxt = ms_r + 32'h1;
                end
            end
            default: begin
                state_nxt = st_idle;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            state_r <= st_idle;
            idx_r <= 6'h00;
            first_r <= 6'h00;
            cnt_r <= 3'h0;
            dw_r <= 16'h0;
            ms_r <= 32'h0;
            ready_r <= seq_pkg::RST_READY;
            move_r <= 1'b0;
            end_r <= 1'b0;
            tlc_r <= 1'b0;
            alarm_r <= 1'b0;
            run_r <= 1'b0;
            cur_r <= seq_pkg::CUR_RUN;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            first_r <= first_nxt;
            cnt_r <= cnt_nxt;
            dw_r <= dw_nxt;
            ms_r <= ms_nxt;
            ready_r <= ready_nxt;
            move_r <= move_nxt;
            end_r <= end_nxt;
            tlc_r <= tlc_nxt;
            alarm_r <= alarm_nxt;
            run_r <= run_nxt;
            cur_r <= cur_nxt;
        end
    end

    // Speed and ramp follow the entry the engine will run
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            spd_r <= 8'h00;
            ramp_r <= 1'b1;
        end else begin
            spd_r <= ent_n[seq_pkg::SPD_LSB +: 8];
            // Push entries run flat at speed
            ramp_r <= (ent_n[seq_pkg::FN_LSB +: 2] != seq_pkg::FN_PUSH);
        end
    end

    // Outputs straight from flops; bus ready and response tied off
    assign o_hrdata = rdata_r;
    assign o_hreadyout = 1'b1; // Never stalls
    assign o_hresp = 1'b0;
    assign o_mot_run = run_r;
    assign o_mot_seg_no = idx_r;
    assign o_mot_accel_no = first_r;
    assign o_mot_speed = spd_r;
    assign o_mot_ramp_en = ramp_r;
    assign o_mot_current = cur_r;
    assign o_ready = ready_r;
    assign o_move = move_r;
    assign o_end = end_r;
    assign o_torque_limit_reached_out = tlc_r;
    assign o_alarm = alarm_r;
endmodule
`default_nettype wire

// >>> test/engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// Motor engine stand-in: each entry takes a fixed travel time
module engine_model #(
    parameter int TRAVEL = 12
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Run command from the sequencer, press enable from the bench
    input wire logic i_mot_run,
    input wire logic i_press_en,
    // Status back to the sequencer
    output logic o_seg_done,
    output logic o_load_pressed
);
    int cnt; // Travel cycles of the current entry
    // Timer restarts per entry, so linked entries each get full travel
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || !i_mot_run || o_seg_done) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
        o_seg_done <= i_resetn && i_mot_run && !o_seg_done && cnt == TRAVEL;
    end
    // Contact comes early, well before travel ends, and only while moving
    assign o_load_pressed = i_press_en && i_mot_run && cnt > 3;
endmodule
`default_nettype wire

// >>> test/push_link_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Watches status and motor command pins of the sequencer
module push_link_seq_chk (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Status pins
    input wire logic o_ready,
    input wire logic o_move,
    input wire logic o_end,
    input wire logic o_torque_limit_reached_out,
    input wire logic o_alarm,
    // Motor commands
    input wire logic o_mot_run,
    input wire logic [5:0] o_mot_seg_no,
    input wire logic [5:0] o_mot_accel_no,
    input wire logic [7:0] o_mot_speed,
    input wire logic o_mot_ramp_en,
    input wire logic [1:0] o_mot_current
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    move_run_a: assert property (o_move |-> o_mot_run) else $error("move without run");
    dwell_stop_a: assert property ($fell(o_mot_run) |-> !o_move)
        else $error("move left on at stop");
    resume_a: assert property ($rose(o_mot_run) |-> o_move && !o_ready)
        else $error("motion start without move");
    tlc_first_a: assert property ($rose(o_torque_limit_reached_out) |->
        !o_ready ##1 o_ready) else $error("limit flag and ready out of order");
    push_cur_a: assert property ($rose(o_torque_limit_reached_out) |->
        o_mot_current == seq_pkg::CUR_PUSH && !o_move) else $error("push status wrong");
    end_ready_a: assert property ($rose(o_end) |->
        o_ready && !o_mot_run && !o_torque_limit_reached_out) else $error("end state wrong");
    push_speed_a: assert property (o_mot_run && !o_mot_ramp_en |->
        o_mot_speed <= seq_pkg::PUSH_MAX_RPM) else $error("push too fast");
    alarm_idle_a: assert property (o_alarm |-> !o_ready && !o_mot_run)
        else $error("alarm while runnable");
    accel_start_a: assert property (o_mot_run |-> o_mot_accel_no <= o_mot_seg_no)
        else $error("accel entry after current");
    busy_a: assert property (o_mot_run |-> !o_ready) else $error("ready while moving");
    // Main scenarios reached
    cover property ($rose(o_torque_limit_reached_out));
    cover property ($rose(o_alarm));
    cover property ($rose(o_end));
endmodule
bind push_link_seq push_link_seq_chk chk (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .o_ready(o_ready), .o_move(o_move), .o_end(o_end), .o_alarm(o_alarm),
    .o_torque_limit_reached_out(o_torque_limit_reached_out), .o_mot_run(o_mot_run),
    .o_mot_seg_no(o_mot_seg_no), .o_mot_accel_no(o_mot_accel_no), .o_mot_speed(o_mot_speed),
    .o_mot_ramp_en(o_mot_ramp_en), .o_mot_current(o_mot_current));
`default_nettype wire

// >>> test/push_and_linked_motion_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module push_and_linked_motion_sequencer_bench;
    // Bus side
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    wire logic [31:0] hrdata;
    wire logic hrdy;
    // Host and engine side
    logic start = 1'b0;
    logic stop = 1'b0;
    logic press = 1'b0;
    logic [5:0] dsel = 6'h0;
    wire logic seg_done, loaded, run, rdy, mv, endf, torque_limit_reached_out, alm;
    wire logic [5:0] seg, acc;
    wire logic [1:0] cur;
    wire logic [7:0] spd; // Commanded speed of the current entry
    wire logic ramp; // Low for flat push moves
    int mismatches = 0;
    int tests_run = 0;
    int dwell = 0; // Stopped but busy cycles once motion began
    logic seen = 1'b0;
    always #5 clk = ~clk;
    // Short millisecond so dwell of 2 ms is 20 cycles
    push_link_seq #(.MS_CYCLES(10)) uut (.i_clk_sys(clk), .i_resetn(rstn), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
        .o_hresp(), .i_start(start), .i_stop(stop), .i_data_select(dsel),
        .i_seg_done(seg_done), .i_load_pressed(loaded), .o_mot_run(run), .o_mot_seg_no(seg),
        .o_mot_accel_no(acc), .o_mot_speed(spd), .o_mot_ramp_en(ramp), .o_mot_current(cur),
        .o_ready(rdy), .o_move(mv), .o_end(endf), .o_torque_limit_reached_out(torque_limit_reached_out),
        .o_alarm(alm));
    engine_model eng (.i_clk_sys(clk), .i_resetn(rstn), .i_mot_run(run), .i_press_en(press),
        .o_seg_done(seg_done), .o_load_pressed(loaded));
    // Dwell meter; a new start clears it
    always @(posedge clk) begin
        if (start) begin
            seen <= 1'b0;
            dwell <= 0;
        end else if (run) begin
            seen <= 1'b1;
        end else if (seen && !mv && !rdy) begin
            dwell <= dwell + 1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Bounded wait: 0 on ready, 1 on motor run, 2 on bus ready
    task automatic wait_for(input int which, input logic lvl);
        for (int n = 0; n < 3000; n++) begin
            @(posedge clk);
            if ((which == 0 ? rdy : which == 1 ? run : hrdy) === lvl) return;
        end
        mismatches++;
        $display("[FAIL] %0t wait timed out", $time);
        print_verdict();
    endtask
    // Single word transfer; address phase held until bus ready
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_for(2, 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_for(2, 1'b1);
        rd = hrdata;
    endtask
    task automatic put(input int no, input logic [1:0] fn, input logic [7:0] spd);
        bus(1'b1, 32'h100 + 4 * no, {16'h0002, spd, 6'h00, fn});
    endtask
    // Host start handshake
    task automatic start_op(input logic [5:0] no, input logic pr);
        wait_for(0, 1'b1);
        dsel <= no;
        press <= pr;
        @(posedge clk);
        start <= 1'b1;
        wait_for(0, 1'b0);
        start <= 1'b0;
    endtask
    task automatic clear_alarm(input string s);
        repeat (20) @(posedge clk);
        chk(alm, 1'b1);
        chk(run, 1'b0);
        bus(1'b1, 32'h004, 32'h1);
        wait_for(0, 1'b1);
        $display("test %s done", s);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, 32'h000, 32'h0);
        chk(rd, 32'h1);
        bus(1'b0, 32'h050, 32'h0);
        chk(rd, 32'h0);
        $display("test bus done");
        // Chain 1..4 is four linked entries; a wrap into 0 would alarm
        put(0, seq_pkg::FN_PUSH, 8'h1f);
        put(1, seq_pkg::FN_LINKED, 8'h64);
        put(2, seq_pkg::FN_LINKED, 8'h64);
        put(3, seq_pkg::FN_CHAIN_WITH_DWELL, 8'h64);
        put(4, seq_pkg::FN_LINKED, 8'h64);
        put(5, seq_pkg::FN_SINGLE, 8'h64);
        put(8, seq_pkg::FN_PUSH, 8'h1e);
        put(9, seq_pkg::FN_LINKED, 8'h64);
        put(10, seq_pkg::FN_PUSH, 8'h14);
        put(11, seq_pkg::FN_PUSH, 8'h1f);
        for (int i = 20; i < 25; i++) put(i, seq_pkg::FN_LINKED, 8'h64);
        put(25, seq_pkg::FN_SINGLE, 8'h64);
        put(63, seq_pkg::FN_LINKED, 8'h64);
        start_op(6'h01, 1'b0);
        wait_for(0, 1'b1);
        chk(32'(dwell >= 20 && dwell <= 22), 32'h1);
        chk(seg, 6'h05);
        chk(acc, 6'h04);
        chk(endf, 1'b1);
        chk({ramp, spd}, {1'b1, 8'h64});
        $display("test chain done");
        start_op(6'h08, 1'b1);
        wait_for(0, 1'b1);
        chk({torque_limit_reached_out, endf, cur}, {2'b10, seq_pkg::CUR_PUSH});
        chk({ramp, spd}, {1'b0, 8'h1e});
        $display("test push pressed done");
        start_op(6'h08, 1'b0);
        wait_for(0, 1'b1);
        chk({torque_limit_reached_out, endf, cur}, {2'b01, seq_pkg::CUR_PUSH});
        $display("test push free done");
        start_op(6'h09, 1'b1);
        wait_for(0, 1'b1);
        chk({torque_limit_reached_out, seg}, {1'b1, 6'h0a});
        $display("test linked push done");
        start_op(6'h08, 1'b0);
        wait_for(1, 1'b1);
        stop <= 1'b1;
        wait_for(0, 1'b1);
        stop <= 1'b0;
        chk({endf, cur}, {1'b1, seq_pkg::CUR_STOP});
        $display("test stop done");
        start_op(6'h0b, 1'b0);
        clear_alarm("push speed");
        start_op(6'h14, 1'b0);
        clear_alarm("five linked");
        start_op(6'h3f, 1'b0);
        wait_for(0, 1'b1);
        chk({alm, endf, seg}, {2'b01, 6'h3f});
        $display("test last entry done");
        print_verdict();
    end
endmodule
`default_nettype wire
